/* File: inc/old_pkg.sv */
package old_pkg;

	localparam int OP_W = 8;
	localparam int EXT_W = 4;
	localparam int CLK_PER_CYC = 2;
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_4 = 3'h4;
	localparam logic [7:0] OP_CODE_STORE = 8'hA5;
	localparam logic [3:0] EXT_STORE_DEF = 4'h1;
	localparam logic [3:0] EXT_BREAK_DEF = 4'h2;
	localparam logic [4:0] ABS_LOW = 5'h01;
	localparam logic [3:0] ABS_JMP_BIT = 4'h0;

	typedef enum logic [1:0] {
		OLD_IDLE = 2'b00,
		OLD_EXEC = 2'b01,
		OLD_LAST = 2'b11
	} old_state_e;

	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cycles;
		logic reg_valid;
		logic [2:0] reg_num;
		logic abs_valid;
		logic abs_call;
		logic [2:0] abs_high;
		logic code_store;
		logic soft_break;
		logic illegal;
	} old_decode_s;

	typedef struct packed {
		old_state_e state;
		logic [2:0] cyc_left;
		logic phase;
		old_decode_s dec;
		logic cyc_strobe;
		logic done;
	} old_state_s;

endpackage : old_pkg

/* File: hdl/old_decoder.sv */
`timescale 1ns/100ps

module old_decoder #(
	parameter logic [3:0] EXT_STORE = old_pkg::EXT_STORE_DEF,
	parameter logic [3:0] EXT_BREAK = old_pkg::EXT_BREAK_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic [3:0] extended_op_select,
	output old_pkg::old_decode_s dec_now,
	output old_pkg::old_decode_s dec_held,
	output logic busy,
	output logic cyc_strobe,
	output logic exec_done
);

	old_pkg::old_state_s cur_ff;
	old_pkg::old_state_s nxt_cur;
	old_pkg::old_decode_s d;

	// Pure decode of the fetched byte so fetch knows operand count at once
	always_comb begin
		logic [3:0] hi;
		logic [3:0] lo;
		hi = opcode[7:4];
		lo = opcode[3:0];
		d = '0;
		d.len = old_pkg::LEN_1;
		d.cycles = old_pkg::CYC_1;
		d.reg_num = opcode[2:0];
		if (opcode[4:0] == old_pkg::ABS_LOW) begin
			d.len = old_pkg::LEN_2;
			d.cycles = old_pkg::CYC_2;
			d.abs_valid = 1'b1;
			d.abs_call = 1'b1;
			d.abs_high = opcode[7:5];
		end else if (opcode[4:0] == 5'h11) begin
			d.len = old_pkg::LEN_2;
			d.cycles = old_pkg::CYC_2;
			d.abs_valid = 1'b1;
			d.abs_call = 1'b1;
			d.abs_high = opcode[7:5];
		end else if (lo[3]) begin
			d.reg_valid = 1'b1;
			case (hi)
				4'h8, 4'hA: begin
					d.len = old_pkg::LEN_2;
					d.cycles = old_pkg::CYC_2;
				end
				4'h7: d.len = old_pkg::LEN_2;
				4'hB: begin
					d.len = old_pkg::LEN_3;
					d.cycles = old_pkg::CYC_2;
				end
				4'hD: begin
					d.len = old_pkg::LEN_2;
					d.cycles = old_pkg::CYC_2;
				end
				4'h9: d.illegal = 1'b0;
				default: d.len = old_pkg::LEN_1;
			endcase
		end else if (lo[3:1] == 3'h3) begin
			// Indirect @Ri forms, bit 0 picks the pointer
			d.reg_valid = 1'b1;
			d.reg_num = {2'h0, opcode[0]};
			case (hi)
				4'h8, 4'hA: begin
					d.len = old_pkg::LEN_2;
					d.cycles = old_pkg::CYC_2;
				end
				4'h7: d.len = old_pkg::LEN_2;
				4'hB: begin
					d.len = old_pkg::LEN_3;
					d.cycles = old_pkg::CYC_2;
				end
				default: d.len = old_pkg::LEN_1;
			endcase
		end else begin
			case (opcode)
				8'h00, 8'h03, 8'h13, 8'h23, 8'h33: d.len = old_pkg::LEN_1;
				8'h04, 8'h14, 8'hC3, 8'hD3, 8'hB3, 8'hC4, 8'hD4, 8'hE4, 8'hF4:
					d.len = old_pkg::LEN_1;
				8'h84, 8'hA4: d.cycles = old_pkg::CYC_4;
				8'h22, 8'h32, 8'h73, 8'h83, 8'h93, 8'hA3: d.cycles = old_pkg::CYC_2;
				8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: d.cycles = old_pkg::CYC_2;
				8'h02, 8'h12, 8'h90, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
				8'h10, 8'h20, 8'h30, 8'hB4, 8'hB5, 8'hD5: begin
					d.len = old_pkg::LEN_3;
					d.cycles = old_pkg::CYC_2;
				end
				8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'hC0, 8'hD0, 8'h72, 8'h82,
				8'hA0, 8'hB0, 8'h92: begin
					d.len = old_pkg::LEN_2;
					d.cycles = old_pkg::CYC_2;
				end
				old_pkg::OP_CODE_STORE: begin
					if (extended_op_select == EXT_STORE) begin
						d.code_store = 1'b1;
						d.cycles = old_pkg::CYC_2;
					end else if (extended_op_select == EXT_BREAK) begin
						d.soft_break = 1'b1;
					end else begin
						d.illegal = 1'b1;
					end
				end
				default: d.len = old_pkg::LEN_2;
			endcase
		end
		// Unknown select on the extended code stays a harmless one-byte op
		if (opcode == old_pkg::OP_CODE_STORE && d.illegal) begin
			d.len = old_pkg::LEN_1;
		end
	end

	assign dec_now = d;

	// Sequencer: each machine cycle is two clock periods
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.cyc_strobe = 1'b0;
		nxt_cur.done = 1'b0;
		case (cur_ff.state)
			old_pkg::OLD_IDLE: begin
				if (opcode_valid) begin
					nxt_cur.dec = d;
					nxt_cur.cyc_left = d.cycles;
					nxt_cur.phase = 1'b0;
					nxt_cur.state = (d.cycles == old_pkg::CYC_1) ? old_pkg::OLD_LAST : old_pkg::OLD_EXEC;
				end
			end
			old_pkg::OLD_EXEC: begin
				nxt_cur.phase = ~cur_ff.phase;
				if (cur_ff.phase) begin
					nxt_cur.cyc_strobe = 1'b1;
					nxt_cur.cyc_left = cur_ff.cyc_left - 3'h1;
					if (cur_ff.cyc_left == 3'h2) begin
						nxt_cur.state = old_pkg::OLD_LAST;
					end
				end
			end
			old_pkg::OLD_LAST: begin
				nxt_cur.phase = ~cur_ff.phase;
				if (cur_ff.phase) begin
					nxt_cur.cyc_strobe = 1'b1;
					nxt_cur.done = 1'b1;
					nxt_cur.cyc_left = 3'h0;
					nxt_cur.state = old_pkg::OLD_IDLE;
				end
			end
			default: nxt_cur.state = old_pkg::OLD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign dec_held = cur_ff.dec;
	assign busy = (cur_ff.state != old_pkg::OLD_IDLE);
	assign cyc_strobe = cur_ff.cyc_strobe;
	assign exec_done = cur_ff.done;

endmodule : old_decoder

/* File: testbench/old_decoder_sva.sv */
`timescale 1ns/100ps
module old_decoder_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire old_pkg::old_decode_s dec_now,
	input wire old_pkg::old_decode_s dec_held,
	input wire logic busy,
	input wire logic cyc_strobe,
	input wire logic exec_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic take = opcode_valid && !busy;
	a_len_cycles: assert property (
		dec_now.len != 2'h0 && dec_now.cycles inside {3'h1, 3'h2, 3'h4})
		else $error("bad length or cycles");
	a_reg_number: assert property (opcode[7:3] == 5'h1D |->
		dec_now.reg_valid && dec_now.reg_num == opcode[2:0])
		else $error("bad register number");
	a_abs_high: assert property (opcode[3:0] == 4'h1 |->
		dec_now.abs_valid && dec_now.abs_high == opcode[7:5] && dec_now.len == 2'h2)
		else $error("bad absolute decode");
	a_strobe_gap: assert property (
		cyc_strobe && !exec_done |=> !cyc_strobe ##1 cyc_strobe)
		else $error("machine cycle not two clocks");
	a_one_cycle: assert property (
		take && dec_now.cycles == 3'h1 |=> !exec_done [*2] ##1 exec_done)
		else $error("one cycle op wrong length");
	a_four_cycle: assert property (
		take && dec_now.cycles == 3'h4 |=> !exec_done [*8] ##1 exec_done)
		else $error("four cycle op wrong length");
	a_done_idle: assert property (exec_done |-> cyc_strobe && !busy)
		else $error("done without strobe");
	a_held_take: assert property (take |=> dec_held == $past(dec_now))
		else $error("held decode not latched");
endmodule : old_decoder_sva

/* File: testbench/old_fetch_model.sv */
`timescale 1ns/100ps
module old_fetch_model (
	output logic [7:0] opcode,
	output logic opcode_valid,
	input wire logic sys_clk,
	input wire logic busy
);
	initial begin
		opcode = 8'h00;
		opcode_valid = 1'b0;
	end
	task automatic show(input logic [7:0] op);
		@(negedge sys_clk);
		opcode = op;
	endtask : show
	// Request raised only once busy is low at a falling edge, then held for one clock
	task automatic issue(input logic [7:0] op);
		@(negedge sys_clk);
		while (busy) @(negedge sys_clk);
		opcode = op;
		opcode_valid = 1'b1;
		@(negedge sys_clk);
		opcode_valid = 1'b0;
		opcode = ~op;
	endtask : issue
endmodule : old_fetch_model

/* File: testbench/test_opcode_length_cycle_decoder.sv */
`timescale 1ns/100ps
module test_opcode_length_cycle_decoder;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] extended_op_select = 4'h1;
	logic [7:0] opcode;
	logic opcode_valid, busy, cyc_strobe, exec_done;
	old_pkg::old_decode_s dec_now, dec_held;
	int bad_count = 0;
	int n_checks = 0;
	// Opcode, bytes, cycles
	logic [15:0] tab [$] = {16'h2811, 16'h2611, 16'h2521, 16'h2421, 16'h3F11, 16'h3521, 16'h3611,
		16'h3421, 16'h9811, 16'h9521, 16'h9711, 16'h9421, 16'h5332, 16'h4332, 16'h6332, 16'h6611,
		16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hA822, 16'h8F22, 16'h9032, 16'hA312, 16'h9312,
		16'h8312, 16'hE012, 16'hE212, 16'hF312, 16'hF012, 16'hC022, 16'hD022, 16'h8222, 16'h7222,
		16'hB022, 16'hA022, 16'h9222, 16'hA221, 16'h2032, 16'h3032, 16'h1032, 16'h1232, 16'h0232,
		16'h2212, 16'h3212, 16'hB532, 16'hB432, 16'hBF32, 16'hB632, 16'hD822, 16'hD532, 16'hA414};
	always #5 sys_clk = ~sys_clk;
	old_decoder dut (.sys_clk, .rst, .opcode, .opcode_valid, .extended_op_select, .dec_now,
		.dec_held, .busy, .cyc_strobe, .exec_done);
	old_fetch_model fetch (.opcode, .opcode_valid, .sys_clk, .busy);
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic t_table();
		foreach (tab[i]) begin
			fetch.show(tab[i][15:8]);
			#1;
			chk("length", 8'(tab[i][7:4]), 8'(dec_now.len));
			chk("cycles", 8'(tab[i][3:0]), 8'(dec_now.cycles));
		end
	endtask : t_table
	task automatic t_fields();
		fetch.show(8'hF1);
		#1;
		chk("abs high", 8'h07, 8'(dec_now.abs_high));
		fetch.show(8'hEB);
		#1;
		chk("reg num", 8'h03, 8'(dec_now.reg_num));
	endtask : t_fields
	task automatic t_a5();
		for (int i = 1; i < 4; i++) begin
			extended_op_select = 4'(i);
			fetch.show(8'hA5);
			#1;
			chk("store", 8'(4'(i) == old_pkg::EXT_STORE_DEF), 8'(dec_now.code_store));
			chk("break", 8'(4'(i) == old_pkg::EXT_BREAK_DEF), 8'(dec_now.soft_break));
			chk("unknown select", 8'(4'(i) != old_pkg::EXT_STORE_DEF
				&& 4'(i) != old_pkg::EXT_BREAK_DEF), 8'(dec_now.illegal));
			chk("a5 length", 8'h01, 8'(dec_now.len));
		end
		extended_op_select = 4'h1;
	endtask : t_a5
	// Back-to-back takes; edges from take to done must be twice the cycles
	task automatic t_exec(input logic [7:0] op, input logic [7:0] cyc);
		int k = 1;
		fetch.issue(op);
		repeat (20) begin
			@(posedge sys_clk);
			#1;
			if (exec_done === 1'b1) break;
			k++;
		end
		chk("edges to done", cyc * 8'h02, 8'(k));
		chk("held cycles", cyc, 8'(dec_held.cycles));
	endtask : t_exec
	initial begin
		#50000;
		bad_count++;
		$display("mismatch watchdog expected done seen hang");
		summarize();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		t_table();
		t_fields();
		t_a5();
		t_exec(8'h24, 8'h01);
		t_exec(8'h90, 8'h02);
		t_exec(8'hA4, 8'h04);
		t_exec(8'hA5, 8'h02);
		summarize();
	end
endmodule : test_opcode_length_cycle_decoder
bind old_decoder old_decoder_sva u_sva (.sys_clk, .rst, .opcode, .opcode_valid, .dec_now,
	.dec_held, .busy, .cyc_strobe, .exec_done);
